// ===== src/jmtf_framer.sv
// module: mode select, lane control and frame packing of the dual-link framer
`default_nettype none
module jmtf_framer (
   input  wire  logic                  clock_i,             // 125 MHz clock
   input  wire  logic                  reset_n_i,           // sync reset, low
   input  wire  logic [5:0]            avs_address_i,       // byte address
   input  wire  logic                  avs_read_i,          // read request
   input  wire  logic                  avs_write_i,         // write request
   input  wire  logic [31:0]           avs_writedata_i,     // write data
   input  wire  logic [3:0]            avs_byteenable_i,    // byte lanes
   output logic [31:0]                 avs_readdata_o,      // read data
   output logic                        avs_waitrequest_o,   // stall, high
   input  wire  logic                  sample_valid_i,      // one sample set
   input  wire  logic [jmtf_pkg::DATA_W-1:0] chan_a_i_i,    // channel a i
   input  wire  logic [jmtf_pkg::DATA_W-1:0] chan_a_q_i,    // channel a q
   input  wire  logic [jmtf_pkg::DATA_W-1:0] chan_b_i_i,    // channel b i
   input  wire  logic [jmtf_pkg::DATA_W-1:0] chan_b_q_i,    // channel b q
   output logic [jmtf_pkg::LANES-1:0][jmtf_pkg::FRAME_W-1:0] lane_frame_o, // frames
   output logic                        frame_valid_o,       // frame pulse
   output logic                        multiframe_start_o,  // first frame
   output logic [2:0]                  lane_octets_o,       // octets per frame
   output logic [jmtf_pkg::LANES-1:0]  lane_enable_o,       // lane powered
   output logic [jmtf_pkg::LANES-1:0][2:0] lane_id_o,       // lane ids
   output logic [7:0]                  did_a_o,             // link a id
   output logic [7:0]                  did_b_o,             // link b id
   output logic                        enc64_o              // 64b/66b mode
);
   import jmtf_pkg::*;

   //==========
   // register state
   logic        wait_q;
   logic        wait_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [6:0]  mode_q;
   logic [6:0]  mode_d;
   logic [7:0]  km1_q;
   logic [7:0]  km1_d;
   logic        en_q;
   logic        en_d;
   logic [15:0] did_q;
   logic [15:0] did_d;
   logic [14:0] thr0_q;
   logic [14:0] thr0_d;
   logic [14:0] thr1_q;
   logic [14:0] thr1_d;

   //==========
   // frame state
   typedef logic [LINKS-1:0][MAX_WORDS-1:0][WORD_W-1:0] jmtf_buf_t;
   typedef logic [LANES-1:0][FRAME_W-1:0] jmtf_lanes_t;
   jmtf_buf_t   buf_q;
   jmtf_buf_t   buf_d;
   jmtf_lanes_t frm_q;
   jmtf_lanes_t frm_d;
   logic [2:0]  cnt_q;
   logic [2:0]  cnt_d;
   logic [7:0]  fcnt_q;
   logic [7:0]  fcnt_d;
   logic        fval_q;
   logic        fval_d;
   logic        mfs_q;
   logic        mfs_d;

   //==========
   // configuration outputs
   logic [LANES-1:0]      lane_en_q;
   logic [LANES-1:0]      lane_en_d;
   logic [LANES-1:0][2:0] lid_q;
   logic [LANES-1:0][2:0] lid_d;
   logic [7:0]            dida_q;
   logic [7:0]            didb_q;
   logic                  enc_q;
   logic [2:0]            oct_q;

   //==========
   // decoded mode
   jmtf_mode_t mode_cfg;
   logic       active;
   logic [7:0] k_m1;
   logic [8:0] k_fix;
   logic       req;
   logic [31:0] stat;
   logic [31:0] wmerge;

   // an unknown code decodes to all zero, so nothing is framed or powered
   assign mode_cfg = jmtf_lookup(mode_q);
   assign active   = mode_cfg.valid && en_q;
   // f is never zero for a valid code; the guard only keeps the divide legal
   assign k_fix    = 9'((K64_NUMER / ((mode_cfg.f == 3'h0) ? 1 : int'(mode_cfg.f))) - 1);
   // 64b/66b ignores the K register; 8b/10b trusts software's range
   assign k_m1     = mode_cfg.enc64 ? k_fix[7:0] : km1_q;

   //==========
   // packers: channel a carries single-channel data too
   jmtf_word_if wa ();
   jmtf_word_if wb ();

   assign wa.smp_i  = chan_a_i_i;
   assign wa.smp_q  = chan_a_q_i;
   assign wa.thr0   = thr0_q;
   assign wa.thr1   = thr1_q;
   assign wa.bypass = (mode_cfg.decim == 6'h01);
   assign wb.smp_i  = chan_b_i_i;
   assign wb.smp_q  = chan_b_q_i;
   assign wb.thr0   = thr0_q;
   assign wb.thr1   = thr1_q;
   assign wb.bypass = (mode_cfg.decim == 6'h01);

   jmtf_word_pack u_pack_a (
      .w (wa)
   );

   jmtf_word_pack u_pack_b (
      .w (wb)
   );

   //==========
   // status word built from the decoded mode
   always_comb begin
      stat = '0;
      stat[ST_VALID]     = mode_cfg.valid;
      stat[ST_ENC64]     = mode_cfg.enc64;
      stat[ST_DUAL]      = mode_cfg.dual;
      stat[ST_LANES +: 4] = mode_cfg.lanes;
      stat[ST_K +: 8]    = k_m1;
      stat[ST_F +: 3]    = mode_cfg.f;
      stat[ST_S +: 3]    = mode_cfg.s;
      stat[ST_DEC +: 6]  = mode_cfg.decim;
   end

   //==========
   // avalon slave: first cycle loads read data, second drops waitrequest
   assign req = avs_read_i || avs_write_i;

   always_comb begin
      wait_d  = !(req && wait_q);
      rdata_d = rdata_q;
      mode_d  = mode_q;
      km1_d   = km1_q;
      en_d    = en_q;
      did_d   = did_q;
      thr0_d  = thr0_q;
      thr1_d  = thr1_q;
      wmerge  = '0;
      if (avs_read_i && wait_q) begin
         unique case (avs_address_i)
            REG_MODE:  rdata_d = {25'h0000000, mode_q};
            REG_KM1:   rdata_d = {24'h000000, km1_q};
            REG_CTRL:  rdata_d = {31'h00000000, en_q};
            REG_DID:   rdata_d = {16'h0000, did_q};
            REG_THR0:  rdata_d = {17'h00000, thr0_q};
            REG_THR1:  rdata_d = {17'h00000, thr1_q};
            REG_STAT:  rdata_d = stat;
            REG_LANES: rdata_d = {16'h0000, lane_en_q};
            default:   rdata_d = 32'h00000000;
         endcase
      end
      // writes land at the edge where the master sees waitrequest low
      if (avs_write_i && !wait_q) begin
         unique case (avs_address_i)
            REG_MODE: begin
               wmerge = jmtf_merge({25'h0000000, mode_q}, avs_writedata_i, avs_byteenable_i);
               mode_d = wmerge[6:0];
            end
            REG_KM1: begin
               wmerge = jmtf_merge({24'h000000, km1_q}, avs_writedata_i, avs_byteenable_i);
               km1_d  = wmerge[7:0];
            end
            REG_CTRL: begin
               wmerge = jmtf_merge({31'h00000000, en_q}, avs_writedata_i, avs_byteenable_i);
               en_d   = wmerge[CTRL_EN];
            end
            REG_DID: begin
               wmerge = jmtf_merge({16'h0000, did_q}, avs_writedata_i, avs_byteenable_i);
               did_d  = wmerge[15:0];
            end
            REG_THR0: begin
               wmerge = jmtf_merge({17'h00000, thr0_q}, avs_writedata_i, avs_byteenable_i);
               thr0_d = wmerge[14:0];
            end
            REG_THR1: begin
               wmerge = jmtf_merge({17'h00000, thr1_q}, avs_writedata_i, avs_byteenable_i);
               thr1_d = wmerge[14:0];
            end
            default: wmerge = '0;   // read-only and unmapped writes are dropped
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         wait_q  <= 1'b1;
         rdata_q <= '0;
         mode_q  <= RST_MODE;
         km1_q   <= RST_KM1;
         en_q    <= 1'b0;
         did_q   <= RST_DID;
         thr0_q  <= RST_THR;
         thr1_q  <= RST_THR;
      end else begin
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
         mode_q  <= mode_d;
         km1_q   <= km1_d;
         en_q    <= en_d;
         did_q   <= did_d;
         thr0_q  <= thr0_d;
         thr1_q  <= thr1_d;
      end
   end

   //==========
   // frame assembly: collect s sample sets, then spread words over lanes
   always_comb begin
      buf_d  = buf_q;
      frm_d  = frm_q;
      cnt_d  = cnt_q;
      fcnt_d = fcnt_q;
      fval_d = 1'b0;
      mfs_d  = 1'b0;
      if (!active) begin
         cnt_d  = 3'h0;
         fcnt_d = 8'h00;
      end else if (sample_valid_i) begin
         if (mode_cfg.dual) begin
            // each link carries one channel, i then q
            buf_d[0][0] = wa.word_i;
            buf_d[0][1] = wa.word_q;
            buf_d[1][0] = wb.word_i;
            buf_d[1][1] = wb.word_q;
         end else begin
            // link a takes i, link b takes q; the receiver rebuilds order
            buf_d[0][cnt_q[1:0]] = wa.word_i;
            buf_d[1][cnt_q[1:0]] = wa.word_q;
         end
         if (cnt_q == (mode_cfg.s - 3'h1)) begin
            cnt_d  = 3'h0;
            fval_d = 1'b1;
            mfs_d  = (fcnt_q == 8'h00);
            fcnt_d = (fcnt_q == k_m1) ? 8'h00 : fcnt_q + 8'h01;
            for (int k = 0; k < LINKS; k++) begin
               for (int l = 0; l < LANES_PER_LINK; l++) begin
                  // unused lanes send zeros; first word sits in the top octets
                  frm_d[k*LANES_PER_LINK+l] = '0;
                  if (l < int'(mode_cfg.lanes)) begin
                     if (mode_cfg.f == 3'h4) begin
                        frm_d[k*LANES_PER_LINK+l] =
                           {buf_d[k][(2*l) % MAX_WORDS],
                            buf_d[k][(2*l+1) % MAX_WORDS]};
                     end else begin
                        frm_d[k*LANES_PER_LINK+l] =
                           {buf_d[k][l % MAX_WORDS], 16'h0000};
                     end
                  end
               end
            end
         end else begin
            cnt_d = cnt_q + 3'h1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         buf_q  <= '0;
         frm_q  <= '0;
         cnt_q  <= 3'h0;
         fcnt_q <= 8'h00;
         fval_q <= 1'b0;
         mfs_q  <= 1'b0;
      end else begin
         buf_q  <= buf_d;
         frm_q  <= frm_d;
         cnt_q  <= cnt_d;
         fcnt_q <= fcnt_d;
         fval_q <= fval_d;
         mfs_q  <= mfs_d;
      end
   end

   //==========
   // lane power follows the mode, not the enable bit; lane ids are fixed per lane
   always_comb begin
      lane_en_d = '0;
      lid_d     = '0;
      for (int k = 0; k < LINKS; k++) begin
         for (int l = 0; l < LANES_PER_LINK; l++) begin
            // lowest lanes of both links run, the rest power down
            lane_en_d[k*LANES_PER_LINK+l] = mode_cfg.valid &&
                                            (l < int'(mode_cfg.lanes));
            lid_d[k*LANES_PER_LINK+l] = 3'(l);
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         lane_en_q <= '0;
         lid_q     <= '0;
         dida_q    <= 8'h00;
         didb_q    <= 8'h00;
         enc_q     <= 1'b0;
         oct_q     <= 3'h0;
      end else begin
         lane_en_q <= lane_en_d;
         lid_q     <= lid_d;
         dida_q    <= did_q[7:0];
         didb_q    <= did_q[15:8];
         enc_q     <= mode_cfg.enc64;
         oct_q     <= mode_cfg.f;
      end
   end

   //==========
   // outputs straight from flops
   assign avs_readdata_o     = rdata_q;
   assign avs_waitrequest_o  = wait_q;
   assign lane_frame_o       = frm_q;
   assign frame_valid_o      = fval_q;
   assign multiframe_start_o = mfs_q;
   assign lane_octets_o      = oct_q;
   assign lane_enable_o      = lane_en_q;
   assign lane_id_o          = lid_q;
   assign did_a_o            = dida_q;
   assign did_b_o            = didb_q;
   assign enc64_o            = enc_q;
endmodule
`default_nettype wire

// ===== src/jmtf_pkg.sv
// package: constants, register map and mode table of the mode transport framer
//==========
`default_nettype none
package jmtf_pkg;
   //==========
   // geometry
   localparam int unsigned LINKS          = 2;
   localparam int unsigned LANES_PER_LINK = 8;
   localparam int unsigned LANES          = 16;
   localparam int unsigned MAX_WORDS      = 4;
   localparam int unsigned WORD_W         = 16;
   localparam int unsigned DATA_W         = 15;
   localparam int unsigned FRAME_W        = 32;
   localparam int unsigned K64_NUMER      = 256;   // 8 * 32 * E with E = 1
   localparam logic [11:0] OFFSET_FLIP    = 12'h800;
   localparam logic [3:0]  TAIL_BITS      = 4'h0;
   //==========
   // register map, byte offsets
   localparam logic [5:0]  REG_MODE  = 6'h00;
   localparam logic [5:0]  REG_KM1   = 6'h04;
   localparam logic [5:0]  REG_CTRL  = 6'h08;
   localparam logic [5:0]  REG_DID   = 6'h0C;
   localparam logic [5:0]  REG_THR0  = 6'h10;
   localparam logic [5:0]  REG_THR1  = 6'h14;
   localparam logic [5:0]  REG_STAT  = 6'h18;
   localparam logic [5:0]  REG_LANES = 6'h1C;
   localparam logic [6:0]  RST_MODE  = 7'h3B;
   localparam logic [7:0]  RST_KM1   = 8'h0F;
   localparam logic [15:0] RST_DID   = 16'h0000;
   localparam logic [14:0] RST_THR   = 15'h7FFF;
   localparam int unsigned CTRL_EN   = 0;
   localparam int unsigned ST_VALID  = 0;
   localparam int unsigned ST_ENC64  = 1;
   localparam int unsigned ST_DUAL   = 2;
   localparam int unsigned ST_LANES  = 4;
   localparam int unsigned ST_K      = 8;
   localparam int unsigned ST_F      = 16;
   localparam int unsigned ST_S      = 20;
   localparam int unsigned ST_DEC    = 24;

   typedef struct packed {
      logic       valid;
      logic       enc64;
      logic       dual;
      logic [5:0] decim;
      logic [3:0] lanes;
      logic [2:0] f;
      logic [2:0] s;
   } jmtf_mode_t;

   function automatic jmtf_mode_t jmtf_lookup(input logic [6:0] code);
      unique case (code)
         7'h3B: jmtf_lookup = '{1'b1, 1'b1, 1'b1, 6'h10, 4'h1, 3'h4, 3'h1};
         7'h3C: jmtf_lookup = '{1'b1, 1'b1, 1'b1, 6'h10, 4'h2, 3'h2, 3'h1};
         7'h3D: jmtf_lookup = '{1'b1, 1'b0, 1'b0, 6'h10, 4'h1, 3'h2, 3'h1};
         7'h3E: jmtf_lookup = '{1'b1, 1'b0, 1'b0, 6'h10, 4'h2, 3'h2, 3'h2};
         7'h3F: jmtf_lookup = '{1'b1, 1'b0, 1'b0, 6'h10, 4'h4, 3'h2, 3'h4};
         7'h40: jmtf_lookup = '{1'b1, 1'b1, 1'b0, 6'h10, 4'h1, 3'h2, 3'h1};
         7'h41: jmtf_lookup = '{1'b1, 1'b1, 1'b0, 6'h10, 4'h2, 3'h2, 3'h2};
         7'h42: jmtf_lookup = '{1'b1, 1'b0, 1'b1, 6'h20, 4'h1, 3'h4, 3'h1};
         7'h43: jmtf_lookup = '{1'b1, 1'b0, 1'b1, 6'h20, 4'h2, 3'h2, 3'h1};
         7'h44: jmtf_lookup = '{1'b1, 1'b1, 1'b1, 6'h20, 4'h1, 3'h4, 3'h1};
         7'h45: jmtf_lookup = '{1'b1, 1'b0, 1'b0, 6'h20, 4'h1, 3'h2, 3'h1};
         7'h46: jmtf_lookup = '{1'b1, 1'b0, 1'b0, 6'h20, 4'h2, 3'h2, 3'h2};
         7'h47: jmtf_lookup = '{1'b1, 1'b1, 1'b0, 6'h20, 4'h1, 3'h2, 3'h1};
         default: jmtf_lookup = '0;
      endcase
   endfunction

   // byte-enable merge of a bus write into a stored word
   function automatic logic [31:0] jmtf_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
      for (int b = 0; b < 4; b++) begin
         jmtf_merge[8*b +: 8] = be[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
      end
   endfunction
endpackage
`default_nettype wire

// ===== src/jmtf_word_if.sv
// interface: one channel's samples in, packed transport words out
`default_nettype none
interface jmtf_word_if;
   logic [14:0] smp_i;
   logic [14:0] smp_q;
   logic [14:0] thr0;
   logic [14:0] thr1;
   logic        bypass;
   logic [15:0] word_i;
   logic [15:0] word_q;
   modport feed (output smp_i, smp_q, thr0, thr1, bypass, input word_i, word_q);
   modport pack (input smp_i, smp_q, thr0, thr1, bypass, output word_i, word_q);
endinterface
`default_nettype wire

// ===== src/jmtf_word_pack.sv
// module: packs one channel's complex sample into two transport words
`default_nettype none
module jmtf_word_pack (
   jmtf_word_if.pack w   // samples and thresholds in, words out
);
   import jmtf_pkg::*;
   logic [DATA_W-1:0] mag_i;
   logic [DATA_W-1:0] mag_q;
   logic              flag0;
   logic              flag1;
   logic [11:0]       raw_i;
   logic [11:0]       raw_q;

   //==========
   // magnitudes: the most negative value still fits unsigned in 15 bits
   assign mag_i = w.smp_i[DATA_W-1] ? (~w.smp_i + 15'h0001) : w.smp_i;
   assign mag_q = w.smp_q[DATA_W-1] ? (~w.smp_q + 15'h0001) : w.smp_q;
   // either part over the threshold flags the sample
   assign flag0 = (mag_i > w.thr0) || (mag_q > w.thr0);
   assign flag1 = (mag_i > w.thr1) || (mag_q > w.thr1);

   //==========
   // bypass keeps the top 12 bits as offset binary with zero tail
   assign raw_i = w.smp_i[DATA_W-1 -: 12] ^ OFFSET_FLIP;
   assign raw_q = w.smp_q[DATA_W-1 -: 12] ^ OFFSET_FLIP;
   // msb of the sample leads the word; flag rides in the lsb
   assign w.word_i = w.bypass ? {raw_i, TAIL_BITS} : {w.smp_i, flag0};
   assign w.word_q = w.bypass ? {raw_q, TAIL_BITS} : {w.smp_q, flag1};
endmodule
`default_nettype wire

// ===== dv/jmtf_framer_sva.sv
// checker: port-level assertions of the mode transport framer
`default_nettype none
module jmtf_framer_sva (
   input wire logic                          clock_i,            // clock
   input wire logic                          reset_n_i,          // reset, low
   input wire logic                          avs_read_i,         // read
   input wire logic                          avs_write_i,        // write
   input wire logic                          avs_waitrequest_o,  // stall
   input wire logic                          sample_valid_i,     // set valid
   input wire logic [jmtf_pkg::DATA_W-1:0]   chan_a_i_i,         // a i
   input wire logic [jmtf_pkg::DATA_W-1:0]   chan_b_q_i,         // b q
   input wire logic [15:0][31:0]             lane_frame_o,       // frames
   input wire logic                          frame_valid_o,      // frame pulse
   input wire logic                          multiframe_start_o, // first frame
   input wire logic [2:0]                    lane_octets_o,      // F
   input wire logic [15:0]                   lane_enable_o,      // lanes on
   input wire logic [15:0][2:0]              lane_id_o,          // lane ids
   input wire logic                          enc64_o             // 64b/66b
);
   import jmtf_pkg::*;
   localparam logic [15:0][2:0] ID_EXP = {2{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}};
   logic [7:0] mf_q;
   logic [7:0] mf_d;
   logic [7:0] k_exp;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   //==========
   // frames since the last multiframe start; a restart resyncs the count
   always_comb begin
      mf_d = mf_q;
      if (frame_valid_o) mf_d = multiframe_start_o ? 8'h01 : mf_q + 8'h01;
   end
   always_ff @(posedge clock_i) begin
      mf_q <= reset_n_i ? mf_d : 8'h00;
   end
   assign k_exp = (lane_octets_o == 3'h4) ? 8'h40 : 8'h80;
   sequence s_req;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_ack;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   //==========
   // properties
   a_bus_answer: assert property (s_req |=> s_ack) else $error("bus answer late");
   a_lane_ids: assert property (reset_n_i |=> lane_id_o == ID_EXP)
      else $error("lane id wrong");
   a_lanes_low: assert property (reset_n_i |=> lane_enable_o[15:8] == lane_enable_o[7:0]
      && lane_enable_o[7:0] inside {8'h00, 8'h01, 8'h03, 8'h0F}) else $error("lane set wrong");
   a_off_invalid: assert property (reset_n_i |=> (lane_octets_o == 3'h0)
      == (lane_enable_o == 16'h0000)) else $error("invalid mode lanes");
   a_frame_cause: assert property (frame_valid_o |-> $past(sample_valid_i))
      else $error("frame without sample");
   a_map_dual: assert property (frame_valid_o && lane_octets_o == 3'h4 |->
      lane_frame_o[0][31:17] == $past(chan_a_i_i) && lane_frame_o[8][15:1] == $past(chan_b_q_i))
      else $error("dual map wrong");
   a_tail_zero: assert property (frame_valid_o && lane_octets_o == 3'h2 |->
      lane_frame_o[0][15:0] == 16'h0000 && lane_frame_o[8][15:0] == 16'h0000)
      else $error("tail not zero");
   a_mf_period: assert property (frame_valid_o && enc64_o && mf_q == k_exp
      |-> multiframe_start_o) else $error("multiframe length wrong");
   a_mf_pulse: assert property (multiframe_start_o |-> frame_valid_o) else $error("lone start");
endmodule
bind jmtf_framer jmtf_framer_sva u_sva (.clock_i(clock_i), .reset_n_i(reset_n_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
   .sample_valid_i(sample_valid_i), .chan_a_i_i(chan_a_i_i), .chan_b_q_i(chan_b_q_i),
   .lane_frame_o(lane_frame_o), .frame_valid_o(frame_valid_o),
   .multiframe_start_o(multiframe_start_o), .lane_octets_o(lane_octets_o),
   .lane_enable_o(lane_enable_o), .lane_id_o(lane_id_o), .enc64_o(enc64_o));
`default_nettype wire

// ===== dv/jmtf_rx_model.sv
// model: far-side receiver that listens on the lowest lane of each link
`default_nettype none
module jmtf_rx_model (
   input wire logic        clock_i,  // clock
   input wire logic        frame_i,  // frame pulse
   input wire logic [31:0] lane_a_i, // lowest lane, link a
   input wire logic [31:0] lane_b_i, // lowest lane, link b
   output logic     [31:0] got_a_o,  // last frame, link a
   output logic     [31:0] got_b_o,  // last frame, link b
   output logic     [15:0] count_o   // frames taken
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] n_q = 16'h0000;
   // only the lowest lanes are wired to this side
   always_ff @(posedge clock_i) begin
      if (frame_i) begin
         got_a_o <= lane_a_i;
         got_b_o <= lane_b_i;
         n_q <= n_q + 16'h0001;
      end
   end
   assign count_o = n_q;
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// testbench: registers, mode table and frame packing of the framer
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import jmtf_pkg::*;
   logic              clock_i = 1'b0, reset_n_i = 1'b0, rd = 1'b0, wr = 1'b0, sv = 1'b0;
   logic [5:0]        adr = 6'h00;
   logic [3:0]        be = 4'h0;
   logic [31:0]       wd = 32'h0, rdo, got_a, got_b, q, st;
   logic [14:0]       ai = 15'h0, aq = 15'h0, bi = 15'h0, bq = 15'h0, iv, qv;
   logic [15:0][31:0] fr;
   logic [15:0][2:0]  lid;
   logic [15:0]       len, cnt, c0;
   logic [7:0]        da, db, kx, msk;
   logic [2:0]        oct;
   logic              wt, fv, mfs, e64;
   logic [3:0]        ln[13] = '{1, 2, 1, 2, 4, 1, 2, 1, 2, 1, 1, 2, 1};
   logic [2:0]        f[13] = '{4, 2, 2, 2, 2, 2, 2, 4, 2, 4, 2, 2, 2};
   logic [2:0]        s[13] = '{1, 1, 1, 2, 4, 1, 2, 1, 1, 1, 1, 2, 1};
   logic [12:0]       e6 = 13'b1001001100011, du = 13'b0001110000011;
   int                miscompares = 0, samples_checked = 0;
   jmtf_framer uut (.clock_i(clock_i), .reset_n_i(reset_n_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdo), .avs_waitrequest_o(wt), .sample_valid_i(sv), .chan_a_i_i(ai),
      .chan_a_q_i(aq), .chan_b_i_i(bi), .chan_b_q_i(bq), .lane_frame_o(fr),
      .frame_valid_o(fv), .multiframe_start_o(mfs), .lane_octets_o(oct),
      .lane_enable_o(len), .lane_id_o(lid), .did_a_o(da), .did_b_o(db), .enc64_o(e64));
   jmtf_rx_model rx (.clock_i(clock_i), .frame_i(fv), .lane_a_i(fr[0]), .lane_b_i(fr[8]),
      .got_a_o(got_a), .got_b_o(got_b), .count_o(cnt));
   //==========
   // shared tasks
   task automatic stop_test;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // one transfer; request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      int n;
      n = 0;
      @(posedge clock_i);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      be <= b;
      // waitrequest and read data are taken at the same rising edge
      do begin
         @(posedge clock_i);
         n++;
      end while (wt !== 1'b0 && n < 20);
      if (n >= 20) miscompares++;
      q = rdo;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'h0);
      chk("register", e, q);
   endtask
   task automatic smp(input logic [14:0] a, b, c, d);
      @(posedge clock_i);
      sv <= 1'b1;
      ai <= a;
      aq <= b;
      bi <= c;
      bq <= d;
   endtask
   task automatic wframe;
      int n;
      n = 0;
      @(posedge clock_i);
      sv <= 1'b0;
      do begin
         @(negedge clock_i);
         n++;
      end while (fv !== 1'b1 && n < 20);
      if (n >= 20) miscompares++;
   endtask
   initial begin
      forever #4 clock_i = ~clock_i;
   end
   // hang guard, well beyond the few hundred cycles the tests take
   initial begin
      #300000;
      miscompares++;
      stop_test;
   end
   //==========
   // main sequence
   initial begin
      repeat (3) @(posedge clock_i);
      reset_n_i <= 1'b1;
      // configuration outputs are registered one edge after release
      @(posedge clock_i);
      @(negedge clock_i);
      chk("lane enable", 32'h0101, len);
      for (int i = 0; i < 16; i++) chk("lane id", i % 8, lid[i]);
      rchk(REG_MODE, {25'h0, RST_MODE});
      rchk(REG_KM1, {24'h0, RST_KM1});
      rchk(REG_THR1, {17'h0, RST_THR});
      bus(1'b1, 6'h20, 32'hFFFFFFFF, 4'hF);
      rchk(6'h20, 32'h0);
      bus(1'b1, REG_STAT, 32'h0, 4'hF);
      bus(1'b1, REG_DID, 32'h0000A55A, 4'h3);
      bus(1'b1, REG_DID, 32'hFFFF3CFF, 4'h2);
      rchk(REG_DID, 32'h00003C5A);
      chk("link ids", 32'h3C5A, {db, da});
      bus(1'b1, REG_KM1, 32'h17, 4'hF);
      // every code of the table, links disabled meanwhile
      for (int i = 0; i < 13; i++) begin
         bus(1'b1, REG_MODE, 32'(59 + i), 4'hF);
         kx = e6[i] ? 8'((256 / f[i]) - 1) : 8'h17;
         msk = 8'((16'h1 << ln[i]) - 16'h1);
         st = {2'b0, (i < 7) ? 6'h10 : 6'h20, 1'b0, s[i], 1'b0, f[i], kx, ln[i], 1'b0, du[i],
               e6[i], 1'b1};
         rchk(REG_STAT, st);
         rchk(REG_LANES, {16'h0, msk, msk});
         chk("lanes", {msk, msk}, len);
      end
      foreach (st[i]) if (i < 2) begin
         bus(1'b1, REG_MODE, i ? 32'd72 : 32'd58, 4'hF);
         rchk(REG_LANES, 32'h0);
         chk("octets", 32'h0, oct);
      end
      // dual channel packing and flags
      bus(1'b1, REG_MODE, 32'd59, 4'hF);
      bus(1'b1, REG_THR0, 32'd100, 4'hF);
      bus(1'b1, REG_THR1, 32'd200, 4'hF);
      bus(1'b1, REG_CTRL, 32'h1, 4'hF);
      c0 = cnt;
      smp(15'd150, 15'h7F6A, 15'd100, 15'd201);
      wframe;
      chk("lane a", {15'd150, 1'b1, 15'h7F6A, 1'b0}, fr[0]);
      chk("lane b", {15'd100, 1'b1, 15'd201, 1'b1}, fr[8]);
      chk("start", 32'h1, mfs);
      for (int k = 0; k < 70; k++) smp(15'(k), 15'(k + 3), 15'(k + 5), 15'(k + 7));
      wframe;
      repeat (2) @(negedge clock_i);
      chk("rx count", c0 + 16'd71, cnt);
      chk("rx a", {15'd69, 1'b0, 15'd72, 1'b0}, got_a);
      // samples while disabled are dropped
      bus(1'b1, REG_CTRL, 32'h0, 4'hF);
      smp(15'd1, 15'd2, 15'd3, 15'd4);
      @(posedge clock_i);
      sv <= 1'b0;
      repeat (4) @(negedge clock_i);
      chk("rx idle", c0 + 16'd71, cnt);
      // single channel, four sets per frame
      bus(1'b1, REG_MODE, 32'd63, 4'hF);
      bus(1'b1, REG_CTRL, 32'h1, 4'hF);
      for (int k = 0; k < 4; k++) smp(15'(50 + 60 * k), 15'(100 * k), 15'h0, 15'h0);
      wframe;
      for (int k = 0; k < 4; k++) begin
         iv = 15'(50 + 60 * k);
         qv = 15'(100 * k);
         chk("i word", {iv, iv > 15'd100, 16'h0}, fr[k]);
         chk("q word", {qv, qv > 15'd200, 16'h0}, fr[8 + k]);
         chk("idle lane", 32'h0, fr[4 + k] | fr[12 + k]);
      end
      stop_test;
   end
endmodule
`default_nettype wire
